//--- sbam_pkg.sv
// Constants shared by the script branch and accumulator move block.
// Assumes one interpreter clock and decoded command fields from the frame parser.
`default_nettype none
package sbam_pkg;
    // Opcodes of the handled instructions
    localparam logic [7:0] OP_CALL = 8'h15;
    localparam logic [7:0] OP_MOVE = 8'h2e;
    localparam logic [7:0] OP_RESTART = 8'h30;
    localparam logic [7:0] OP_DEC_BRANCH = 8'h31;
    localparam logic [7:0] OP_RETURN = 8'h0c;
    localparam logic [7:0] OP_ROTATE_INC = 8'h01;
    localparam logic [7:0] OP_ROTATE_DEC = 8'h02;
    localparam logic [7:0] OP_HALT = 8'h03;
    // Reply status codes
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    // Call conditions
    localparam logic [7:0] COND_ZERO = 8'h00;
    localparam logic [7:0] COND_NOT_ZERO = 8'h01;
    localparam logic [7:0] COND_EQUAL = 8'h02;
    localparam logic [7:0] COND_NOT_EQUAL = 8'h03;
    localparam logic [7:0] COND_GREATER = 8'h04;
    localparam logic [7:0] COND_GREATER_EQUAL = 8'h05;
    localparam logic [7:0] COND_LOWER = 8'h06;
    localparam logic [7:0] COND_LOWER_EQUAL = 8'h07;
    localparam logic [7:0] COND_TIMEOUT_ERROR = 8'h08;
    localparam logic [7:0] COND_EXTERNAL_ALARM = 8'h09;
    localparam logic [7:0] COND_DEVIATION_ERROR = 8'h0a;
    localparam logic [7:0] COND_POSITION_ERROR = 8'h0b;
    // Move types
    localparam logic [7:0] MOVE_ABSOLUTE_TARGET = 8'h00;
    localparam logic [7:0] MOVE_RELATIVE_OFFSET = 8'h01;
    localparam logic [7:0] MOVE_STORED_COORDINATE = 8'h02;
    // Flag bit positions
    localparam int FLAG_ZERO = 0;
    localparam int FLAG_EQUAL = 1;
    localparam int FLAG_GREATER = 2;
    localparam int FLAG_LOWER = 3;
    // Error input bit positions
    localparam int ERR_TIMEOUT = 0;
    localparam int ERR_ALARM = 1;
    localparam int ERR_DEVIATION = 2;
    localparam int ERR_POSITION = 3;
    // Sizes and reset values
    localparam int STACK_DEPTH = 8;
    localparam logic [3:0] STACK_FULL = 4'h8;
    localparam logic [3:0] SP_RESET = 4'h0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [1:0] AXIS_LAST = 2'h2;
    localparam int VAR_COUNT = 256;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT_VAR = 1'b1
    } sbam_state_type;
endpackage
`default_nettype wire

//--- sbam_var_mem.sv
// User variable store, 256 words of 32 bits, one write and one read port.
// Read data come out of a register one clock after the read enable.
`default_nettype none
module sbam_var_mem (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    // Read port
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    output logic [31:0] rd_data_o
);
    logic [31:0] mem_q [0:sbam_pkg::VAR_COUNT-1];

    // Array holds no reset so it maps onto block memory
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 32'h0000_0000;
        end else if (rd_en_i) begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule
`default_nettype wire

//--- sbam_core.sv
// Flow commands and accumulator move of the motion command interpreter.
// Assumes decoded frame fields from a parser on the same clock.
`default_nettype none
module sbam_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Command request
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_standalone_i,
    input wire logic [7:0] cmd_opcode_i,
    input wire logic [7:0] cmd_type_i,
    input wire logic [7:0] cmd_bank_i,
    input wire logic [31:0] cmd_value_i,
    // Reply
    output logic rsp_valid_o,
    output logic [7:0] rsp_status_o,
    output logic [7:0] rsp_opcode_o,
    // Program flow
    output logic [15:0] pc_o,
    output logic [3:0] stack_level_o,
    output logic restart_o,
    // Comparison flags and error levels
    input wire logic flag_load_i,
    input wire logic [3:0] flag_i,
    input wire logic [3:0] err_i,
    // User variable write from arithmetic logic
    input wire logic var_wr_i,
    input wire logic [7:0] var_idx_i,
    input wire logic [31:0] var_data_i,
    // Motion
    input wire logic [31:0] acc_i,
    input wire logic [95:0] act_pos_i,
    output logic [7:0] stored_idx_o,
    input wire logic [31:0] stored_pos_i,
    input wire logic [1:0] stored_axis_i,
    input wire logic [2:0] pos_reached_i,
    output logic move_valid_o,
    output logic [1:0] move_axis_o,
    output logic [31:0] move_target_o,
    output logic [2:0] pos_mode_o,
    output logic abort_o,
    output logic [1:0] abort_axis_o
);
    sbam_pkg::sbam_state_type state_q, state_d;
    logic [15:0] pc_q, pc_d, jmp_q, jmp_d;
    logic [3:0] sp_q, sp_d, flag_q, flag_d;
    logic [15:0] stack_q [0:sbam_pkg::STACK_DEPTH-1];
    logic [15:0] stack_d [0:sbam_pkg::STACK_DEPTH-1];
    logic [7:0] vidx_q, vidx_d, status_q, status_d, rop_q, rop_d;
    logic [2:0] pos_q, pos_d;
    logic rsp_q, rsp_d, restart_q, restart_d, mv_q, mv_d, abort_q, abort_d;
    logic [1:0] mv_axis_q, mv_axis_d, ab_axis_q, ab_axis_d;
    logic [31:0] mv_tgt_q, mv_tgt_d, act_sel, var_rd, var_dec;
    logic take, flow_op, mem_wr, mem_rd;
    logic [7:0] mem_waddr;
    logic [31:0] mem_wdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    function automatic logic cond_met(input logic [7:0] c, input logic [3:0] f,
                                      input logic [3:0] e);
        logic r;
        r = 1'b0;
        case (c)
            sbam_pkg::COND_ZERO: r = f[sbam_pkg::FLAG_ZERO];
            sbam_pkg::COND_NOT_ZERO: r = !f[sbam_pkg::FLAG_ZERO];
            sbam_pkg::COND_EQUAL: r = f[sbam_pkg::FLAG_EQUAL];
            sbam_pkg::COND_NOT_EQUAL: r = !f[sbam_pkg::FLAG_EQUAL];
            sbam_pkg::COND_GREATER: r = f[sbam_pkg::FLAG_GREATER];
            sbam_pkg::COND_GREATER_EQUAL: r = f[sbam_pkg::FLAG_GREATER] | f[sbam_pkg::FLAG_EQUAL];
            sbam_pkg::COND_LOWER: r = f[sbam_pkg::FLAG_LOWER];
            sbam_pkg::COND_LOWER_EQUAL: r = f[sbam_pkg::FLAG_LOWER] | f[sbam_pkg::FLAG_EQUAL];
            sbam_pkg::COND_TIMEOUT_ERROR: r = e[sbam_pkg::ERR_TIMEOUT];
            sbam_pkg::COND_EXTERNAL_ALARM: r = e[sbam_pkg::ERR_ALARM];
            sbam_pkg::COND_DEVIATION_ERROR: r = e[sbam_pkg::ERR_DEVIATION];
            sbam_pkg::COND_POSITION_ERROR: r = e[sbam_pkg::ERR_POSITION];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign cmd_ready_o = (state_q == sbam_pkg::ST_IDLE);
    assign take = cmd_valid_i && cmd_ready_o;
    assign flow_op = (cmd_opcode_i == sbam_pkg::OP_DEC_BRANCH)
        || (cmd_opcode_i == sbam_pkg::OP_CALL)
        || (cmd_opcode_i == sbam_pkg::OP_RESTART) || (cmd_opcode_i == sbam_pkg::OP_RETURN);
    assign act_sel = act_pos_i[{cmd_bank_i[1:0], 5'h00} +: 32];
    assign stored_idx_o = cmd_bank_i;
    assign var_dec = var_rd - 32'h0000_0001;

    sbam_var_mem u_var_mem (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_en_i(mem_rd),
        .rd_addr_i(cmd_type_i),
        .rd_data_o(var_rd)
    );

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        jmp_d = jmp_q;
        sp_d = sp_q;
        stack_d = stack_q;
        vidx_d = vidx_q;
        pos_d = pos_q & ~pos_reached_i;
        rsp_d = 1'b0;
        status_d = status_q;
        rop_d = rop_q;
        restart_d = 1'b0;
        mv_d = 1'b0;
        mv_axis_d = mv_axis_q;
        mv_tgt_d = mv_tgt_q;
        abort_d = 1'b0;
        ab_axis_d = ab_axis_q;
        mem_rd = 1'b0;
        // Outside variable writes are dropped while a decrement is in flight or a command is taken
        mem_wr = var_wr_i && cmd_ready_o && !take;
        mem_waddr = var_idx_i;
        mem_wdata = var_data_i;
        flag_d = flag_load_i ? flag_i : flag_q;
        case (state_q)
            sbam_pkg::ST_IDLE: begin
                if (take) begin
                    rsp_d = 1'b1;
                    rop_d = cmd_opcode_i;
                    status_d = sbam_pkg::STATUS_OK;
                    if (cmd_standalone_i) begin
                        pc_d = pc_q + 16'h0001;
                    end
                    if (flow_op && !cmd_standalone_i) begin
                        status_d = sbam_pkg::STATUS_BAD_CMD;
                    end else begin
                        case (cmd_opcode_i)
                            sbam_pkg::OP_DEC_BRANCH: begin
                                rsp_d = 1'b0;
                                pc_d = pc_q;
                                mem_rd = 1'b1;
                                vidx_d = cmd_type_i;
                                jmp_d = cmd_value_i[15:0];
                                state_d = sbam_pkg::ST_WAIT_VAR;
                            end
                            sbam_pkg::OP_CALL: begin
                                if (cmd_type_i > sbam_pkg::COND_POSITION_ERROR) begin
                                    status_d = sbam_pkg::STATUS_BAD_TYPE;
                                end else if (cond_met(cmd_type_i, flag_q, err_i)
                                             && sp_q != sbam_pkg::STACK_FULL) begin
                                    stack_d[sp_q[2:0]] = pc_q + 16'h0001;
                                    sp_d = sp_q + 4'h1;
                                    pc_d = cmd_value_i[15:0];
                                end
                            end
                            sbam_pkg::OP_RETURN: begin
                                if (sp_q != sbam_pkg::SP_RESET) begin
                                    sp_d = sp_q - 4'h1;
                                    pc_d = stack_q[3'(sp_q - 4'h1)];
                                end else begin
                                    status_d = sbam_pkg::STATUS_BAD_CMD;
                                end
                            end
                            sbam_pkg::OP_RESTART: begin
                                sp_d = sbam_pkg::SP_RESET;
                                // A compare landing in the same cycle still wins
                                flag_d = flag_load_i ? flag_i : 4'h0;
                                restart_d = 1'b1;
                                pc_d = cmd_value_i[15:0];
                            end
                            sbam_pkg::OP_MOVE: begin
                                if (cmd_type_i > sbam_pkg::MOVE_STORED_COORDINATE) begin
                                    status_d = sbam_pkg::STATUS_BAD_TYPE;
                                end else if (cmd_type_i != sbam_pkg::MOVE_STORED_COORDINATE
                                             && cmd_bank_i > {6'h00, sbam_pkg::AXIS_LAST}) begin
                                    status_d = sbam_pkg::STATUS_BAD_VALUE;
                                end else begin
                                    mv_d = 1'b1;
                                    mv_axis_d = cmd_bank_i[1:0];
                                    if (cmd_type_i == sbam_pkg::MOVE_ABSOLUTE_TARGET) begin
                                        mv_tgt_d = acc_i;
                                    end else if (cmd_type_i == sbam_pkg::MOVE_RELATIVE_OFFSET) begin
                                        mv_tgt_d = act_sel + acc_i;
                                    end else begin
                                        mv_axis_d = stored_axis_i;
                                        mv_tgt_d = stored_pos_i;
                                    end
                                    pos_d[mv_axis_d] = 1'b1;
                                end
                            end
                            sbam_pkg::OP_HALT, sbam_pkg::OP_ROTATE_INC,
                            sbam_pkg::OP_ROTATE_DEC: begin
                                if (cmd_bank_i > {6'h00, sbam_pkg::AXIS_LAST}) begin
                                    status_d = sbam_pkg::STATUS_BAD_VALUE;
                                end else begin
                                    abort_d = pos_q[cmd_bank_i[1:0]];
                                    ab_axis_d = cmd_bank_i[1:0];
                                    pos_d[cmd_bank_i[1:0]] = 1'b0;
                                end
                            end
                            default: begin
                                status_d = sbam_pkg::STATUS_BAD_CMD;
                            end
                        endcase
                    end
                end
            end
            sbam_pkg::ST_WAIT_VAR: begin
                mem_wr = 1'b1;
                mem_waddr = vidx_q;
                mem_wdata = var_dec;
                pc_d = (var_dec != 32'h0000_0000) ? jmp_q : pc_q + 16'h0001;
                rsp_d = 1'b1;
                rop_d = sbam_pkg::OP_DEC_BRANCH;
                status_d = sbam_pkg::STATUS_OK;
                state_d = sbam_pkg::ST_IDLE;
            end
            default: begin
                state_d = sbam_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= sbam_pkg::ST_IDLE;
            pc_q <= sbam_pkg::PC_RESET;
            jmp_q <= 16'h0000;
            sp_q <= sbam_pkg::SP_RESET;
            for (int i = 0; i < sbam_pkg::STACK_DEPTH; i++) begin
                stack_q[i] <= 16'h0000;
            end
            vidx_q <= 8'h00;
            flag_q <= 4'h0;
            pos_q <= 3'h0;
            rsp_q <= 1'b0;
            status_q <= 8'h00;
            rop_q <= 8'h00;
            restart_q <= 1'b0;
            mv_q <= 1'b0;
            mv_axis_q <= 2'h0;
            mv_tgt_q <= 32'h0000_0000;
            abort_q <= 1'b0;
            ab_axis_q <= 2'h0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            jmp_q <= jmp_d;
            sp_q <= sp_d;
            stack_q <= stack_d;
            vidx_q <= vidx_d;
            flag_q <= flag_d;
            pos_q <= pos_d;
            rsp_q <= rsp_d;
            status_q <= status_d;
            rop_q <= rop_d;
            restart_q <= restart_d;
            mv_q <= mv_d;
            mv_axis_q <= mv_axis_d;
            mv_tgt_q <= mv_tgt_d;
            abort_q <= abort_d;
            ab_axis_q <= ab_axis_d;
        end
    end

    assign rsp_valid_o = rsp_q;
    assign rsp_status_o = status_q;
    assign rsp_opcode_o = rop_q;
    assign pc_o = pc_q;
    assign stack_level_o = sp_q;
    assign restart_o = restart_q;
    assign move_valid_o = mv_q;
    assign move_axis_o = mv_axis_q;
    assign move_target_o = mv_tgt_q;
    assign pos_mode_o = pos_q;
    assign abort_o = abort_q;
    assign abort_axis_o = ab_axis_q;

    logic call_take, move_ok;
    assign call_take = take && cmd_standalone_i && cmd_opcode_i == sbam_pkg::OP_CALL
        && cmd_type_i <= sbam_pkg::COND_POSITION_ERROR;
    assign move_ok = take && cmd_opcode_i == sbam_pkg::OP_MOVE
        && cmd_type_i == sbam_pkg::MOVE_ABSOLUTE_TARGET && cmd_bank_i <= 8'h02;

    chk_dec_branch: assert property (
        take && cmd_standalone_i && cmd_opcode_i == sbam_pkg::OP_DEC_BRANCH
        |=> ##1 rsp_valid_o && pc_o == (($past(var_rd) != 32'h0000_0001) ? $past(jmp_q)
        : $past(pc_q, 2) + 16'h0001))
        else $error("decrement branch did not finish in two cycles");
    chk_call_push: assert property (
        call_take && cond_met(cmd_type_i, flag_q, err_i) && sp_q != sbam_pkg::STACK_FULL
        |=> pc_o == $past(cmd_value_i[15:0]) && sp_q == $past(sp_q) + 4'h1)
        else $error("met call did not push and jump");
    chk_call_skip: assert property (
        call_take && !cond_met(cmd_type_i, flag_q, err_i)
        |=> sp_q == $past(sp_q) && pc_o == $past(pc_q) + 16'h0001)
        else $error("unmet call changed stack or skipped wrong");
    chk_stack_depth: assert property (sp_q <= sbam_pkg::STACK_FULL)
        else $error("return stack deeper than eight");
    chk_full_ignore: assert property (
        call_take && sp_q == sbam_pkg::STACK_FULL
        |=> sp_q == sbam_pkg::STACK_FULL && pc_o == $past(pc_q) + 16'h0001)
        else $error("call on full stack was not ignored");
    chk_move_reply: assert property (
        move_ok |=> move_valid_o && rsp_valid_o && move_target_o == $past(acc_i)
        && pos_mode_o[move_axis_o])
        else $error("move not set up with its reply");
    chk_offset_wrap: assert property (
        take && cmd_opcode_i == sbam_pkg::OP_MOVE
        && cmd_type_i == sbam_pkg::MOVE_RELATIVE_OFFSET && cmd_bank_i == 8'h02
        |=> move_target_o == $past(acc_i + act_pos_i[95:64]))
        else $error("relative target not a wrapped sum");
    chk_abort_clear: assert property (
        take && cmd_opcode_i == sbam_pkg::OP_HALT && cmd_bank_i == 8'h01
        |=> !pos_mode_o[1] && $past(pos_q[1]) == abort_o)
        else $error("halt did not abandon the move");
    chk_restart_clear: assert property (
        take && cmd_standalone_i && cmd_opcode_i == sbam_pkg::OP_RESTART
        |=> restart_o && sp_q == 4'h0 && pc_o == $past(cmd_value_i[15:0]))
        else $error("restart did not clear and reload");
    chk_direct_refuse: assert property (
        take && !cmd_standalone_i && flow_op
        |=> rsp_status_o == sbam_pkg::STATUS_BAD_CMD && $stable(pc_o) && $stable(sp_q))
        else $error("flow command ran in direct mode");
endmodule
`default_nettype wire

//--- sbam_fix_note.sv
// Holds no logic of its own.
// Assumes nothing of its surroundings.

//--- sbam_host.sv
// Host model issuing decoded command frames to the interpreter.
// Assumes the shared interpreter clock; drives on falling edges.
`default_nettype none
module sbam_host (
    // Clock
    input wire logic clk_i,
    // Command
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic cmd_standalone_o,
    output logic [7:0] cmd_opcode_o,
    output logic [7:0] cmd_type_o,
    output logic [7:0] cmd_bank_o,
    output logic [31:0] cmd_value_o,
    // Reply
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_status_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_standalone_o = 1'b0;
        {cmd_opcode_o, cmd_type_o, cmd_bank_o, cmd_value_o} = '1;
    end
    // Fields in frame order, value bytes packed most significant first
    task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
        input logic [31:0] val, input logic sa, output logic [7:0] st, output bit ok);
        int n;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_standalone_o = sa;
        {cmd_opcode_o, cmd_type_o, cmd_bank_o, cmd_value_o} = {op, typ, bank, val};
        n = 0;
        while (cmd_ready_i !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        // Released fields must not keep showing the last command
        {cmd_opcode_o, cmd_type_o, cmd_bank_o, cmd_value_o} = ~{op, typ, bank, val};
        cmd_standalone_o = ~sa;
        while (rsp_valid_i !== 1'b1 && n < 16) begin
            @(negedge clk_i);
            n++;
        end
        st = rsp_status_i;
        ok = n < 16;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the flow and accumulator move interpreter.
// Assumes the host model drives commands; the bench drives all other inputs.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    wire logic cmd_valid, cmd_ready, cmd_sa, rsp_valid, restart, move_valid, abort;
    wire logic [7:0] cmd_op, cmd_type, cmd_bank, rsp_status, rsp_op, stored_idx;
    wire logic [31:0] cmd_value, move_target;
    wire logic [15:0] pc;
    wire logic [3:0] stack_level;
    wire logic [1:0] move_axis, abort_axis;
    wire logic [2:0] pos_mode;
    logic flag_load = 1'b0;
    logic [3:0] flags = 4'h0, errs = 4'h0, fl_m = 4'h0, sp = 4'h0;
    logic var_wr = 1'b0;
    logic [7:0] var_idx = 8'h00;
    logic [31:0] var_data = 32'h0, acc = 32'h0, stored_pos = 32'h0;
    logic [95:0] act_pos = 96'h0;
    logic [1:0] stored_axis = 2'h0;
    logic [7:0] idx_at_take = 8'h00;
    logic [15:0] pc_m = 16'h0;
    logic [15:0] stk [8];
    int error_cnt = 0;
    int check_count = 0;
    always #10 clk_i = ~clk_i;
    // Index is combinational, so catch it while the request stands
    always @(posedge clk_i) if (cmd_valid && cmd_ready) idx_at_take <= stored_idx;
    sbam_host i_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
        .cmd_standalone_o(cmd_sa), .cmd_opcode_o(cmd_op), .cmd_type_o(cmd_type),
        .cmd_bank_o(cmd_bank), .cmd_value_o(cmd_value), .rsp_valid_i(rsp_valid),
        .rsp_status_i(rsp_status));
    sbam_core i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_standalone_i(cmd_sa), .cmd_opcode_i(cmd_op),
        .cmd_type_i(cmd_type), .cmd_bank_i(cmd_bank), .cmd_value_i(cmd_value),
        .rsp_valid_o(rsp_valid), .rsp_status_o(rsp_status), .rsp_opcode_o(rsp_op), .pc_o(pc),
        .stack_level_o(stack_level), .restart_o(restart), .flag_load_i(flag_load),
        .flag_i(flags), .err_i(errs), .var_wr_i(var_wr), .var_idx_i(var_idx),
        .var_data_i(var_data), .acc_i(acc), .act_pos_i(act_pos), .stored_idx_o(stored_idx),
        .stored_pos_i(stored_pos), .stored_axis_i(stored_axis), .pos_reached_i(3'h0),
        .move_valid_o(move_valid), .move_axis_o(move_axis), .move_target_o(move_target),
        .pos_mode_o(pos_mode), .abort_o(abort), .abort_axis_o(abort_axis));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
        input logic [31:0] val, input logic sa, input logic [7:0] exp_st, input bit flow);
        logic [7:0] st;
        bit ok;
        i_host.send(op, typ, bank, val, sa, st, ok);
        if (!ok) begin
            error_cnt++;
            $display("ERROR at %0t: no reply", $time);
            tally_and_finish();
        end else begin
            check({24'h0, st}, {24'h0, exp_st});
            check({24'h0, rsp_op}, {24'h0, op});
            if (flow) check({16'h0, pc}, {16'h0, pc_m});
            if (flow) check({28'h0, stack_level}, {28'h0, sp});
        end
    endtask
    function automatic logic met(input int t);
        logic [11:0] c;
        c = {errs, fl_m[3] | fl_m[1], fl_m[3], fl_m[2] | fl_m[1], fl_m[2], ~fl_m[1],
            fl_m[1], ~fl_m[0], fl_m[0]};
        return c[t];
    endfunction
    task automatic t_calls(input logic [3:0] f, input logic [3:0] e);
        logic [15:0] tgt;
        @(negedge clk_i);
        flags = f;
        errs = e;
        flag_load = 1'b1;
        fl_m = f;
        @(negedge clk_i);
        flag_load = 1'b0;
        // Live flags differ from the stored ones from here on
        flags = ~f;
        for (int t = 0; t < 12; t++) begin
            tgt = 16'h0100 + 16'(t);
            if (met(t) && sp < 4'h8) begin
                stk[sp[2:0]] = pc_m + 16'h1;
                sp++;
                pc_m = tgt;
            end else pc_m = pc_m + 16'h1;
            run(sbam_pkg::OP_CALL, 8'(t), 8'h0, {16'h0, tgt}, 1'b1, sbam_pkg::STATUS_OK,
                1);
        end
        $display("test calls done");
    endtask
    task automatic t_flow();
        while (sp != 4'h0) begin
            sp--;
            pc_m = stk[sp[2:0]];
            run(sbam_pkg::OP_RETURN, 8'h0, 8'h0, 32'h0, 1'b1, sbam_pkg::STATUS_OK, 1);
        end
        run(sbam_pkg::OP_RETURN, 8'h0, 8'h0, 32'h0, 1'b1, sbam_pkg::STATUS_BAD_CMD, 0);
        @(negedge clk_i);
        var_idx = 8'h2a;
        var_data = 32'h2;
        var_wr = 1'b1;
        @(negedge clk_i);
        var_wr = 1'b0;
        // Counter 2 jumps, 1 falls through, 0 wraps and jumps again
        for (int i = 0; i < 3; i++) begin
            pc_m = (i == 1) ? 16'h2 : 16'h1;
            run(sbam_pkg::OP_DEC_BRANCH, 8'h2a, 8'h0, 32'h1, 1'b1, sbam_pkg::STATUS_OK, 1);
        end
        stk[0] = pc_m + 16'h1;
        sp = 4'h1;
        pc_m = 16'h0104;
        run(sbam_pkg::OP_CALL, 8'h04, 8'h0, 32'h0104, 1'b1, sbam_pkg::STATUS_OK, 1);
        sp = 4'h0;
        pc_m = 16'h000a;
        run(sbam_pkg::OP_RESTART, 8'h0, 8'h0, 32'h000a, 1'b1, sbam_pkg::STATUS_OK, 1);
        check({31'h0, restart}, 32'h1);
        foreach (stk[i]) if (i < 4) begin
            run(i == 0 ? sbam_pkg::OP_CALL : i == 1 ? sbam_pkg::OP_RESTART : i == 2 ?
                sbam_pkg::OP_DEC_BRANCH : sbam_pkg::OP_RETURN, 8'h04, 8'h0, 32'h55, 1'b0,
                sbam_pkg::STATUS_BAD_CMD, 1);
        end
        $display("test flow done");
    endtask
    task automatic mv(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
        input logic [7:0] st, input logic [1:0] ax, input logic [31:0] tgt, input logic [2:0] pm);
        run(op, typ, bank, 32'h0, 1'b0, st, 1);
        check({29'h0, pos_mode}, {29'h0, pm});
        if (op == sbam_pkg::OP_MOVE && st == sbam_pkg::STATUS_OK) begin
            check({move_valid, 29'h0, move_axis}, {1'b1, 29'h0, ax});
            check(move_target, tgt);
        end else if (op != sbam_pkg::OP_MOVE) begin
            check({abort, 29'h0, abort_axis}, {1'b1, 29'h0, ax});
        end
    endtask
    task automatic t_moves();
        acc = 32'h12345678;
        mv(sbam_pkg::OP_MOVE, sbam_pkg::MOVE_ABSOLUTE_TARGET, 8'h1, 8'h64, 2'h1, acc,
            3'b010);
        // Offset added to the actual position, wraps past zero
        act_pos[95:64] = 32'hfffffff0;
        acc = 32'h20;
        // Issued straight after the previous reply
        mv(sbam_pkg::OP_MOVE, sbam_pkg::MOVE_RELATIVE_OFFSET, 8'h2, 8'h64, 2'h2, 32'h10,
            3'b110);
        stored_pos = 32'habc;
        mv(sbam_pkg::OP_MOVE, sbam_pkg::MOVE_STORED_COORDINATE, 8'h5, 8'h64, 2'h0, 32'habc,
            3'b111);
        check({24'h0, idx_at_take}, 32'h5);
        mv(sbam_pkg::OP_MOVE, 8'h03, 8'h0, sbam_pkg::STATUS_BAD_TYPE, 2'h0, 32'h0, 3'b111);
        mv(sbam_pkg::OP_MOVE, 8'h00, 8'h3, sbam_pkg::STATUS_BAD_VALUE, 2'h0, 32'h0, 3'b111);
        mv(sbam_pkg::OP_HALT, 8'h0, 8'h1, 8'h64, 2'h1, 32'h0, 3'b101);
        mv(sbam_pkg::OP_ROTATE_INC, 8'h0, 8'h2, 8'h64, 2'h2, 32'h0, 3'b001);
        mv(sbam_pkg::OP_ROTATE_DEC, 8'h0, 8'h0, 8'h64, 2'h0, 32'h0, 3'b000);
        run(sbam_pkg::OP_HALT, 8'h0, 8'h0, 32'h0, 1'b0, sbam_pkg::STATUS_OK, 1);
        check({31'h0, abort}, 32'h0);
        $display("test moves done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        check({cmd_ready, 11'h0, stack_level, pc}, 32'h80000000);
        t_calls(4'b0011, 4'b0001);
        t_calls(4'b0100, 4'b1110);
        t_flow();
        t_moves();
        tally_and_finish();
    end
endmodule
`default_nettype wire
